// [rtl/sense_ctl_pkg.sv]
package sense_ctl_pkg;

  localparam logic [7:0] ADDR_SENSE_CONTROL_4 = 8'h10;
  localparam logic [7:0] ADDR_SENSE_CONTROL_5 = 8'h11;
  localparam logic [7:0] ADDR_SENSE_CONTROL_6 = 8'h12;

  localparam logic [7:0] RST_SENSE_CONTROL_4 = 8'h80;
  localparam logic [7:0] RST_SENSE_CONTROL_5 = 8'h00;
  localparam logic [7:0] RST_SENSE_CONTROL_6 = 8'h40;

  localparam int AMP3_OR_BACKEMF_CALIBRATE_BIT = 0;
  localparam int SENSE_SIX_WRITE_UNLOCK_BIT    = 5;
  localparam int BACKEMF_OFFSET_SOURCE_BIT     = 6;
  localparam int GATE_DRIVER_ACTIVE_OVR_BIT    = 0;

  // Calibration duration of the amplifier offset engine
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CAL_TIME_NS   = 1000;
  localparam int CAL_CYCLES    = (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CAL_CNT_W     = 8;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } cal_state_t;

endpackage

// [rtl/offset_cal_engine.sv]
`timescale 1ns/1ps
module offset_cal_engine
(
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  input  wire logic i_start,
  input  wire logic i_backemf_mode,
  output logic      o_busy,
  output logic      o_backemf_q,
  output logic      o_done
);
  import sense_ctl_pkg::*;

  cal_state_t             state_q;
  logic [CAL_CNT_W-1:0]   cnt_q;
  logic                   done_q;

  localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_CYCLES - 1);

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= CAL_IDLE;
      cnt_q   <= '0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        CAL_IDLE: begin
          if (i_start) begin
            state_q <= CAL_RUN;
            cnt_q   <= '0;
          end
        end
        CAL_RUN: begin
          if (cnt_q == CAL_LAST) begin
            state_q <= CAL_IDLE;
            done_q  <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // Mode is latched so a change of sense enable mid-run does not matter
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_backemf_q <= 1'b0;
    end else if (i_start && state_q == CAL_IDLE) begin
      o_backemf_q <= i_backemf_mode;
    end
  end

  assign o_busy = (state_q == CAL_RUN);
  assign o_done = done_q;

  chk_cal_run_length: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_start && state_q == CAL_IDLE) |=> o_busy [*8] ##[1:300] o_done)
    else $error("Calibration did not finish in time");

endmodule

// [rtl/sense_control_6_regs.sv]
`timescale 1ns/1ps
// Contract
// - Writes to sense control 6 are taken only while the unlock bit is one.
// - Bit 6 selects offset source, one is factory trim; resets to one.
// - Finished backEMF offset calibration clears the offset source bit to zero.
// - Bit 0 enables gate driver active override; resets to zero.
// - Register sits at address 0x12 and resets to 0x40.
// - Unlock is bit 5 of address 0x11, resets zero, blocks writes when zero.
// - Writing one to calibrate bit starts calibration unless one is already running; bit clears itself when done.
module sense_control_6_regs
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_backemf_sense_enable,
  output logic      [7:0] o_reg_rdata,
  output logic            o_backemf_offset_source,
  output logic            o_gate_driver_active_override,
  output logic            o_cal_busy,
  output logic            o_cal_backemf,
  output logic            o_cal_done
);
  import sense_ctl_pkg::*;

  logic [7:0] ctl4_q;
  logic [7:0] ctl5_q;
  logic [7:0] ctl6_q;
  logic [7:0] rdata_q;
  logic       cal_start;
  logic       cal_busy;
  logic       cal_backemf;
  logic       cal_done;
  logic       wr4;
  logic       wr5;
  logic       wr6;
  logic       bemf_done;

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] r4,
                                          input logic [7:0] r5, input logic [7:0] r6);
    read_mux = 8'h00;
    if (addr == ADDR_SENSE_CONTROL_4) read_mux = r4;
    if (addr == ADDR_SENSE_CONTROL_5) read_mux = r5;
    if (addr == ADDR_SENSE_CONTROL_6) read_mux = r6;
  endfunction

  assign wr4 = i_reg_wr && (i_reg_addr == ADDR_SENSE_CONTROL_4);
  assign wr5 = i_reg_wr && (i_reg_addr == ADDR_SENSE_CONTROL_5);
  assign wr6 = i_reg_wr && (i_reg_addr == ADDR_SENSE_CONTROL_6)
               && ctl5_q[SENSE_SIX_WRITE_UNLOCK_BIT];
  assign cal_start = wr4 && i_reg_wdata[AMP3_OR_BACKEMF_CALIBRATE_BIT] && !cal_busy;
  assign bemf_done = cal_done && cal_backemf;

  offset_cal_engine u_cal (
    .i_clk_sys      (i_clk_sys),
    .i_rst_b        (i_rst_b),
    .i_start        (cal_start),
    .i_backemf_mode (i_backemf_sense_enable),
    .o_busy         (cal_busy),
    .o_backemf_q    (cal_backemf),
    .o_done         (cal_done)
  );

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl5_q <= RST_SENSE_CONTROL_5;
    end else if (wr5) begin
      ctl5_q <= i_reg_wdata;
    end
  end

  // Calibrate bit stays set while the engine runs, then clears itself
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl4_q <= RST_SENSE_CONTROL_4;
    end else begin
      if (wr4) begin
        ctl4_q[7:1] <= i_reg_wdata[7:1];
      end
      if (cal_start) begin
        ctl4_q[AMP3_OR_BACKEMF_CALIBRATE_BIT] <= 1'b1;
      end else if (cal_done) begin
        ctl4_q[AMP3_OR_BACKEMF_CALIBRATE_BIT] <= 1'b0;
      end
    end
  end

  // BackEMF calibration completion wins over a same-cycle software write of the offset source bit
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl6_q <= RST_SENSE_CONTROL_6;
    end else begin
      if (wr6) begin
        ctl6_q <= i_reg_wdata;
      end
      if (bemf_done) begin
        ctl6_q[BACKEMF_OFFSET_SOURCE_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 8'h00;
    end else if (i_reg_rd) begin
      rdata_q <= read_mux(i_reg_addr, ctl4_q, ctl5_q, ctl6_q);
    end
  end

  assign o_reg_rdata                   = rdata_q;
  assign o_backemf_offset_source       = ctl6_q[BACKEMF_OFFSET_SOURCE_BIT];
  assign o_gate_driver_active_override = ctl6_q[GATE_DRIVER_ACTIVE_OVR_BIT];
  assign o_cal_busy                    = cal_busy;
  assign o_cal_backemf                 = cal_backemf;
  assign o_cal_done                    = cal_done;

  chk_locked_write_held: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_reg_wr && i_reg_addr == ADDR_SENSE_CONTROL_6 && !ctl5_q[SENSE_SIX_WRITE_UNLOCK_BIT]
     && !bemf_done) |=> $stable(ctl6_q))
    else $error("Locked write changed sense control 6");

  chk_unlocked_write_taken: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_reg_wr && i_reg_addr == ADDR_SENSE_CONTROL_6 && ctl5_q[SENSE_SIX_WRITE_UNLOCK_BIT]
     && !bemf_done) |=> (ctl6_q == $past(i_reg_wdata)))
    else $error("Unlocked write not stored");

  chk_offset_cleared: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    bemf_done |=> !o_backemf_offset_source)
    else $error("Offset source not cleared after calibration");

  chk_offset_output: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $rose(o_backemf_offset_source) |-> $past(wr6)
      && $past(i_reg_wdata[BACKEMF_OFFSET_SOURCE_BIT]))
    else $error("Offset source set without an unlocked write");

  chk_override_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $changed(o_gate_driver_active_override) |-> $past(wr6)
      && (o_gate_driver_active_override == $past(i_reg_wdata[GATE_DRIVER_ACTIVE_OVR_BIT])))
    else $error("Active override changed without an unlocked write");

  chk_reset_value: assert property (@(posedge i_clk_sys)
    $rose(i_rst_b) |-> (ctl6_q == RST_SENSE_CONTROL_6) && !ctl5_q[SENSE_SIX_WRITE_UNLOCK_BIT])
    else $error("Reset value of sense control 6 wrong");

  chk_cal_bit_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (cal_done && !cal_start) |=> (!ctl4_q[AMP3_OR_BACKEMF_CALIBRATE_BIT] && !cal_busy))
    else $error("Calibrate bit did not clear itself");

  chk_read_contents: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_reg_rd && i_reg_addr == ADDR_SENSE_CONTROL_6) |=> (o_reg_rdata == $past(ctl6_q)))
    else $error("Read did not return sense control 6 contents");

  // Busy cycles counted so run length is checked without a long repetition
  logic [CAL_CNT_W-1:0] busy_run_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_run_q <= '0;
    end else if (cal_busy) begin
      busy_run_q <= busy_run_q + 1'b1;
    end else begin
      busy_run_q <= '0;
    end
  end

  chk_busy_bounded: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    cal_busy |-> (busy_run_q < CAL_CNT_W'(CAL_CYCLES)))
    else $error("Calibration ran past its length");

  chk_busy_full_length: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    cal_done |-> (busy_run_q == CAL_CNT_W'(CAL_CYCLES)))
    else $error("Calibration ended early");

  chk_cal_done_time: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    cal_start |-> ##201 cal_done)
    else $error("Calibration done pulse at wrong cycle");

  chk_start_sets_busy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    cal_start |=> (cal_busy && ctl4_q[AMP3_OR_BACKEMF_CALIBRATE_BIT]))
    else $error("Calibration start not taken");

  chk_cal_bit_busy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    cal_busy |-> ctl4_q[AMP3_OR_BACKEMF_CALIBRATE_BIT])
    else $error("Calibrate bit low while calibration runs");

  chk_mode_latched: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    cal_start |=> (cal_backemf == $past(i_backemf_sense_enable)))
    else $error("Calibration mode not latched at start");

  chk_plain_cal_keeps: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (cal_done && !cal_backemf && !wr6) |=> $stable(o_backemf_offset_source))
    else $error("Amplifier calibration touched offset source");

  chk_unlock_stored: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr5 |=> (ctl5_q == $past(i_reg_wdata)))
    else $error("Sense control 5 write not stored");

  chk_offset_from_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (wr6 && !bemf_done) |=> (o_backemf_offset_source
      == $past(i_reg_wdata[BACKEMF_OFFSET_SOURCE_BIT])))
    else $error("Offset source does not follow write");

  chk_override_from_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr6 |=> (o_gate_driver_active_override
      == $past(i_reg_wdata[GATE_DRIVER_ACTIVE_OVR_BIT])))
    else $error("Active override does not follow write");

  chk_read_unlock: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_reg_rd && i_reg_addr == ADDR_SENSE_CONTROL_5) |=> (o_reg_rdata == $past(ctl5_q)))
    else $error("Read did not return sense control 5 contents");

  chk_read_cal_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_reg_rd && i_reg_addr == ADDR_SENSE_CONTROL_4) |=> (o_reg_rdata == $past(ctl4_q)))
    else $error("Read did not return sense control 4 contents");

  chk_read_unmapped: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_reg_rd && i_reg_addr != ADDR_SENSE_CONTROL_4 && i_reg_addr != ADDR_SENSE_CONTROL_5
     && i_reg_addr != ADDR_SENSE_CONTROL_6) |=> (o_reg_rdata == 8'h00))
    else $error("Unmapped read returned nonzero data");

  chk_rdata_held: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("Read data changed without a read");

endmodule

// [test/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_reg_rdata,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata
);
  initial begin
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
  end
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_reg_wr    <= 1'b1;
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    @(posedge i_clk_sys);
    o_reg_wr    <= 1'b0;
    o_reg_addr  <= ~a;
    o_reg_wdata <= ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_reg_rd   <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_clk_sys);
    o_reg_rd   <= 1'b0;
    o_reg_addr <= ~a;
    #1;
    d = i_reg_rdata;
  endtask
  // Unlock, write with reserved bits zero, lock again
  task automatic write_ctl6(input logic [7:0] d);
    write(8'h11, 8'h20);
    write(8'h12, d & 8'h41);
    write(8'h11, 8'h00);
  endtask
endmodule

// [test/sense_control_6_regs_bench.sv]
`timescale 1ns/1ps
module sense_control_6_regs_bench;
  import sense_ctl_pkg::*;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
  logic       clk;
  logic       rst_b;
  logic       backemf_sense_enable;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic       ofs;
  logic       ovr;
  logic       busy;
  logic       cbemf;
  logic       done;
  int         error_cnt = 0;
  int         num_checks = 0;
  sense_control_6_regs dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_backemf_sense_enable(backemf_sense_enable),
    .o_reg_rdata(rdata), .o_backemf_offset_source(ofs), .o_gate_driver_active_override(ovr),
    .o_cal_busy(busy), .o_cal_backemf(cbemf), .o_cal_done(done));
  spi_host_model host (.i_clk_sys(clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_addr(addr), .o_reg_wdata(wdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic finish_test;
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic test_reset;
    `CHK(ofs, 1'b1)
    `CHK(ovr, 1'b0)
    host.read(ADDR_SENSE_CONTROL_6, rv);
    `CHK(rv, 8'h40)
    host.read(ADDR_SENSE_CONTROL_5, rv);
    `CHK(rv, 8'h00)
  endtask
  task automatic test_locked;
    host.write(ADDR_SENSE_CONTROL_6, 8'h01);
    #1;
    `CHK(ovr, 1'b0)
    host.read(ADDR_SENSE_CONTROL_6, rv);
    `CHK(rv, 8'h40)
    host.read(8'h13, rv);
    `CHK(rv, 8'h00)
  endtask
  task automatic test_unlocked;
    host.write_ctl6(8'hff);
    `CHK(ovr, 1'b1)
    `CHK(ofs, 1'b1)
    host.read(ADDR_SENSE_CONTROL_6, rv);
    `CHK(rv, 8'h41)
    host.write(ADDR_SENSE_CONTROL_6, 8'h00);
    host.read(ADDR_SENSE_CONTROL_6, rv);
    `CHK(rv, 8'h41)
  endtask
  task automatic test_cal;
    int n;
    n = 0;
    @(posedge clk);
    backemf_sense_enable <= 1'b1;
    host.write(ADDR_SENSE_CONTROL_4, 8'h01);
    #1;
    `CHK(busy, 1'b1)
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(done, 1'b1)
    `CHK(n, CAL_CYCLES)
    `CHK(cbemf, 1'b1)
    @(posedge clk);
    #1;
    `CHK(done, 1'b0)
    `CHK(ofs, 1'b0)
    host.read(ADDR_SENSE_CONTROL_6, rv);
    `CHK(rv, 8'h01)
    host.read(ADDR_SENSE_CONTROL_4, rv);
    `CHK(rv[0], 1'b0)
  endtask
  // Amplifier calibration with a refused restart; offset source must stay
  task automatic test_cal_plain;
    int n;
    n = 0;
    @(posedge clk);
    backemf_sense_enable <= 1'b0;
    host.write_ctl6(8'h41);
    `CHK(ofs, 1'b1)
    host.write(ADDR_SENSE_CONTROL_4, 8'h01);
    #1;
    `CHK(busy, 1'b1)
    `CHK(cbemf, 1'b0)
    host.write(ADDR_SENSE_CONTROL_4, 8'h01);
    host.read(ADDR_SENSE_CONTROL_4, rv);
    `CHK(rv[0], 1'b1)
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, CAL_CYCLES - 4)
    @(posedge clk);
    #1;
    `CHK(done, 1'b0)
    `CHK(ofs, 1'b1)
    host.read(ADDR_SENSE_CONTROL_6, rv);
    `CHK(rv, 8'h41)
  endtask
  task automatic test_mid_reset;
    host.write_ctl6(8'h01);
    `CHK(ofs, 1'b0)
    `CHK(ovr, 1'b1)
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    test_reset();
  endtask
  initial begin
    rst_b   = 1'b0;
    backemf_sense_enable = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    test_reset();
    test_locked();
    test_unlocked();
    test_cal();
    test_cal_plain();
    test_mid_reset();
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule
